// >>> bench/ifc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_chk (
  // Clock, reset and bus
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  input wire logic [31:0] O_WB_DAT,
  // Link, lock and comparator
  input wire logic I_LINK_STROBE,
  input wire logic O_SDO,
  input wire logic I_PHASE_ERR,
  input wire logic O_PUMP_ACTIVE,
  input wire logic [1:0] O_DEAD_ZONE_SEL,
  input wire logic O_IF_SENSITIVITY_SEL,
  input wire logic O_DEADLOCK_CLEAR,
  input wire logic O_LOCK
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  logic [3:0] quiet;
  // Cycles since a phase error, saturating so it never wraps
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN || I_PHASE_ERR) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("ack without request");
  a_dat_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data outside ack");
  a_pump_mode: assert property (O_PUMP_ACTIVE == !O_DEAD_ZONE_SEL[1])
    else $error("pump mode does not follow dead zone field");
  a_ctrl_latch: assert property ($changed({O_IF_SENSITIVITY_SEL, O_DEADLOCK_CLEAR,
    O_DEAD_ZONE_SEL}) |-> !I_LINK_STROBE && $past(!I_LINK_STROBE, 2))
    else $error("control outputs changed inside a frame");
  a_sdo_idle: assert property ((!I_LINK_STROBE && O_LOCK) [*6] |-> O_SDO)
    else $error("serial out low while locked");
  a_lock_clean: assert property ($rose(O_LOCK) |-> quiet >= 4'h8)
    else $error("lock rose soon after phase error");
  // Main scenarios reached
  cover property ($rose(O_LOCK));
  cover property ($fell(O_LOCK));
  cover property (O_WB_ACK && O_WB_DAT != 32'h0);
endmodule
bind ifc_top ifc_chk u_chk (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT),
  .I_LINK_STROBE(I_LINK_STROBE), .O_SDO(O_SDO), .I_PHASE_ERR(I_PHASE_ERR),
  .O_PUMP_ACTIVE(O_PUMP_ACTIVE), .O_DEAD_ZONE_SEL(O_DEAD_ZONE_SEL),
  .O_IF_SENSITIVITY_SEL(O_IF_SENSITIVITY_SEL), .O_DEADLOCK_CLEAR(O_DEADLOCK_CLEAR),
  .O_LOCK(O_LOCK));
`default_nettype wire

// >>> bench/ifc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_ctl_model (
  // Link pins toward the block
  output logic o_link_clk,
  output logic o_link_data,
  output logic o_link_strobe,
  // Serial readback
  input wire logic i_sdo
);
  // Link clock idles low; it only runs inside frames
  initial begin
    o_link_clk = 1'b0;
    o_link_data = 1'b0;
    o_link_strobe = 1'b0;
  end
  // Filler then word, MSB first; readback taken at each rising edge
  task automatic frame(input logic [7:0] word, output logic [20:0] rd);
    logic [20:0] tx;
    tx = {13'h0, word};
    // Strobe stays low over five clocks so the block sees every frame gap
    #537 o_link_strobe = 1'b1;
    #1000;
    for (int i = 20; i >= 0; i--) begin
      o_link_data = tx[i];
      #400 o_link_clk = 1'b1;
      rd[i] = i_sdo;
      #400 o_link_clk = 1'b0;
    end
    #400 o_link_strobe = 1'b0;
    o_link_data = ~o_link_data; // Released line shows no stale level
  endtask
endmodule
`default_nettype wire

// >>> bench/test_ifc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_ifc_top;
  // Shortened counts; expectations follow from these
  localparam int GT [4] = '{40, 80, 320, 640};
  localparam int WT [4] = '{30, 30, 70, 70};
  typedef struct {logic [7:0] word; logic sens; logic [1:0] dz; logic deadlock_clear_bit; logic pump;} ifc_row_s;
  ifc_row_s rows [5] = '{'{8'h08, 1'b1, 2'b00, 1'b0, 1'b1}, '{8'h18, 1'b1, 2'b01, 1'b0, 1'b1},
    '{8'h20, 1'b0, 2'b10, 1'b0, 1'b0}, '{8'h78, 1'b1, 2'b11, 1'b1, 1'b0},
    '{8'h00, 1'b0, 2'b00, 1'b0, 1'b1}};
  logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, phase = 1'b0;
  logic station = 1'b1;
  logic [3:0] sel = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [2:0] ifdiv = 3'h0;
  logic ack, sdo, sens, pump, deadlock_clear_bit, lock, irq, lclk, ldata, lstb;
  logic [1:0] dz;
  logic [31:0] rdat;
  int miscompares = 0, tests_run = 0, cyc_cnt = 0;
  ifc_top #(.P_GATE0_CYC(GT[0]), .P_GATE1_CYC(GT[1]), .P_GATE2_CYC(GT[2]),
    .P_GATE3_CYC(GT[3]), .P_WAIT_SHORT_CYC(WT[0]), .P_WAIT_LONG_CYC(WT[2]))
    uut (.I_CLK(clk), .I_RSTN(rstn),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_DAT(rdat), .I_LINK_CLK(lclk),
    .I_LINK_DATA(ldata), .I_LINK_STROBE(lstb), .O_SDO(sdo), .I_IF_INPUT_PIN(ifdiv[2]),
    .I_STATION_PRESENT(station), .O_IF_SENSITIVITY_SEL(sens), .I_PHASE_ERR(phase),
    .O_PUMP_ACTIVE(pump), .O_DEAD_ZONE_SEL(dz), .O_DEADLOCK_CLEAR(deadlock_clear_bit), .O_LOCK(lock),
    .O_IRQ(irq));
  ifc_ctl_model ctl (.o_link_clk(lclk), .o_link_data(ldata), .o_link_strobe(lstb),
    .i_sdo(sdo));
  // Clock, IF pulses every eight cycles, and a hang limit
  always #50 clk = ~clk;
  always @(posedge clk) begin
    ifdiv <= ifdiv + 3'h1;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Classic single cycle; request held until the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rv);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, ack, 1'b1);
    end
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  initial begin
    logic [31:0] d, c;
    logic [20:0] rd;
    int t0, n;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(32'({ack, sdo, sens, pump, dz, deadlock_clear_bit, lock, irq}), 32'ha0);
    chk(rdat, 32'h0);
    wb(1'b0, ifc_pkg::REG_REF_DIV, 32'h0, d);
    chk(d, 32'(ifc_pkg::REF_DIV_RST));
    wb(1'b0, ifc_pkg::REG_LOCK_CFG, 32'h0, d);
    chk(d, 32'h1);
    wb(1'b1, 8'h40, 32'hffffffff, d);
    wb(1'b0, 8'h40, 32'h0, d);
    chk(d, 32'h0);
    $display("test reset done");
    // Control word table: word latched, outputs follow
    foreach (rows[i]) begin
      ctl.frame(rows[i].word, rd);
      repeat (8) @(posedge clk);
      wb(1'b0, ifc_pkg::REG_CTRL, 32'h0, d);
      chk(d, {24'h0, rows[i].word});
      c = 32'({rows[i].sens, rows[i].dz, rows[i].deadlock_clear_bit, rows[i].pump});
      chk(32'({sens, dz, deadlock_clear_bit, pump}), c);
    end
    $display("test control table done");
    // Lock with a twenty-cycle reference period
    wb(1'b1, ifc_pkg::REG_REF_DIV, 32'h14, d);
    repeat (45) @(posedge clk);
    chk(32'(lock), 32'h1);
    phase <= 1'b1;
    repeat (45) @(posedge clk);
    chk(32'(lock), 32'h0);
    ctl.frame(8'h80, rd);
    repeat (8) @(posedge clk);
    chk(32'(sdo), 32'h0);
    phase <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      repeat (25) @(posedge clk);
      wb(1'b0, ifc_pkg::REG_STATUS, 32'h0, d);
      chk(32'(d[ifc_pkg::ST_LOCK]), 32'h1);
    end
    chk(32'(sdo), 32'h1);
    wb(1'b1, ifc_pkg::REG_LOCK_CFG, 32'h0, d);
    phase <= 1'b1;
    repeat (45) @(posedge clk);
    chk(32'(lock), 32'h1);
    phase <= 1'b0;
    repeat (10) @(posedge clk);
    wb(1'b1, ifc_pkg::REG_LOCK_CFG, 32'h1, d);
    repeat (50) @(posedge clk);
    $display("test lock done");
    // Each gate code: wait, gate, count, irq, readout, hold
    for (int g = 0; g < 4; g++) begin
      wb(1'b0, ifc_pkg::REG_STATUS, 32'h0, d);
      chk(32'(d[ifc_pkg::ST_STATION]), 32'h1);
      ctl.frame(8'h28, rd);
      ctl.frame({5'h05, g[1:0], 1'b1}, rd);
      t0 = cyc_cnt;
      n = 0;
      do begin
        wb(1'b0, ifc_pkg::REG_STATUS, 32'h0, d);
        n++;
      end while (d[ifc_pkg::ST_DONE] !== 1'b1 && n < 400);
      chk_rng(32'(cyc_cnt - t0), WT[g] + GT[g], WT[g] + GT[g] + 20);
      wb(1'b0, ifc_pkg::REG_COUNT, 32'h0, c);
      chk_rng(c, GT[g] / 8 - 1, GT[g] / 8 + 1);
      chk(32'(irq), 32'(g != 0));
      if (g == 0) begin
        wb(1'b1, ifc_pkg::REG_IRQ_MASK, 32'h1, d);
      end
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      wb(1'b0, ifc_pkg::REG_IRQ_STAT, 32'h0, d);
      chk(32'(d[ifc_pkg::IRQ_DONE]), 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      ctl.frame({5'h05, g[1:0], 1'b1}, rd);
      chk(32'(rd), {11'h0, 1'b1, c[19:0]});
      repeat (100) @(posedge clk);
      wb(1'b0, ifc_pkg::REG_COUNT, 32'h0, d);
      chk(d, c);
    end
    $display("test gate codes done");
    // Run cleared after a finished count: cleared run drops the held count at once
    ctl.frame(8'h2f, rd);
    ctl.frame(8'h28, rd);
    repeat (8) @(posedge clk);
    wb(1'b0, ifc_pkg::REG_STATUS, 32'h0, d);
    chk(32'(d[1:0]), 32'h0);
    wb(1'b0, ifc_pkg::REG_COUNT, 32'h0, d);
    chk(d, 32'h0);
    $display("test abort done");
    // Station level shown as it stands; byte lanes gate the divider write
    station <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, ifc_pkg::REG_STATUS, 32'h0, d);
    chk(32'(d[ifc_pkg::ST_STATION]), 32'h0);
    sel <= 4'h1;
    wb(1'b1, ifc_pkg::REG_REF_DIV, 32'h0000ffff, d);
    wb(1'b0, ifc_pkg::REG_REF_DIV, 32'h0, d);
    chk(d, 32'h000000ff);
    $display("test station and lanes done");
    end_sim;
  end
endmodule
`default_nettype wire

// >>> rtl/ifc_lock_det.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_lock_det (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Configuration
  input wire logic i_enable,
  input wire logic [ifc_pkg::REF_W-1:0] i_ref_div,
  // Synchronised phase error level
  input wire logic i_phase_err,
  // Lock state, one bit per reference period
  output logic o_locked
);

  typedef struct packed {
    logic [ifc_pkg::REF_W-1:0] cnt;
    logic err_seen;
    logic locked;
  } ifc_lock_s;

  ifc_lock_s r;
  ifc_lock_s next_r;
  logic period_end;

  // One reference period spans ref_div clocks; zero acts as one
  always_comb begin
    next_r = r;
    period_end = (r.cnt >= i_ref_div - 1'b1) || (i_ref_div == '0);
    next_r.err_seen = r.err_seen | i_phase_err;
    if (!i_enable) begin
      next_r.cnt = '0;
      next_r.err_seen = 1'b0;
      next_r.locked = 1'b1;
    end else if (period_end) begin
      // Verdict taken once per whole period
      next_r.locked = ~(r.err_seen | i_phase_err);
      next_r.cnt = '0;
      next_r.err_seen = 1'b0;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  // Starts unlocked until a full clean period has passed
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_locked = r.locked;

endmodule
`default_nettype wire

// >>> rtl/ifc_pkg.sv
package ifc_pkg;

  // Clock rate and timing figures
  localparam int CLK_KHZ = 10_000;
  localparam int GATE_T0_MS = 4;
  localparam int GATE_T1_MS = 8;
  localparam int GATE_T2_MS = 32;
  localparam int GATE_T3_MS = 64;
  // Least figure of each wait range
  localparam int WAIT_SHORT_MS = 3;
  localparam int WAIT_LONG_MS = 7;

  // Widths
  localparam int CNT_W = 20;
  localparam int CW_W = 8;
  localparam int OUT_W = CNT_W + 1;
  localparam int REF_W = 16;
  localparam int IRQ_W = 4;
  localparam int SY_W = 6;

  // Control word bits, shifted in over the serial link
  localparam int CW_RUN = 0;
  localparam int CW_GATE_LO = 1;
  localparam int CW_GATE_HI = 2;
  localparam int CW_IFS = 3;
  localparam int CW_DZ_LO = 4;
  localparam int CW_DZ_HI = 5;
  localparam int CW_DLC = 6;
  localparam int CW_LOCK_PIN = 7;
  localparam logic [CW_W-1:0] CW_RST = 8'h00;

  // Synchroniser lanes
  localparam int SY_DATA = 0;
  localparam int SY_LCLK = 1;
  localparam int SY_STROBE = 2;
  localparam int SY_IF = 3;
  localparam int SY_STATION = 4;
  localparam int SY_PHASE = 5;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_REF_DIV = 8'h14;
  localparam logic [7:0] REG_LOCK_CFG = 8'h18;

  // Status and interrupt bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_STATION = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam int IRQ_LOCK = 2;
  localparam int IRQ_LATCH = 3;

  // Reset values
  localparam logic [REF_W-1:0] REF_DIV_RST = 16'h03e8;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [1:0] {CNT_IDLE, CNT_WAIT, CNT_GATE, CNT_DONE} ifc_cnt_e;

endpackage

// >>> rtl/ifc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Asynchronous inputs
  input wire logic [W-1:0] i_async,
  // Synchronised level and edges
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] lvl;
    logic [W-1:0] prev;
  } ifc_sync_s;

  ifc_sync_s r;
  ifc_sync_s next_r;

  // Two stages, then a third copy for edges; meta feeds lvl only
  always_comb begin
    next_r = r;
    next_r.meta = i_async;
    next_r.lvl = r.meta;
    next_r.prev = r.lvl;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_level = r.lvl;
  assign o_rise = r.lvl & ~r.prev;
  assign o_fall = ~r.lvl & r.prev;

endmodule
`default_nettype wire

// >>> rtl/ifc_top.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ifc_top #(
  parameter int P_GATE0_CYC = ifc_pkg::GATE_T0_MS * ifc_pkg::CLK_KHZ,
  parameter int P_GATE1_CYC = ifc_pkg::GATE_T1_MS * ifc_pkg::CLK_KHZ,
  parameter int P_GATE2_CYC = ifc_pkg::GATE_T2_MS * ifc_pkg::CLK_KHZ,
  parameter int P_GATE3_CYC = ifc_pkg::GATE_T3_MS * ifc_pkg::CLK_KHZ,
  parameter int P_WAIT_SHORT_CYC = ifc_pkg::WAIT_SHORT_MS * ifc_pkg::CLK_KHZ,
  parameter int P_WAIT_LONG_CYC = ifc_pkg::WAIT_LONG_MS * ifc_pkg::CLK_KHZ
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // Wishbone classic slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  // Three-wire serial link from the controller
  input wire logic I_LINK_CLK,
  input wire logic I_LINK_DATA,
  input wire logic I_LINK_STROBE,
  output logic O_SDO,
  // IF stage
  input wire logic I_IF_INPUT_PIN,
  input wire logic I_STATION_PRESENT,
  output logic O_IF_SENSITIVITY_SEL,
  // Phase comparator
  input wire logic I_PHASE_ERR,
  output logic O_PUMP_ACTIVE,
  output logic [1:0] O_DEAD_ZONE_SEL,
  output logic O_DEADLOCK_CLEAR,
  // Interrupt and lock
  output logic O_LOCK,
  output logic O_IRQ
);

  typedef struct packed {
    ifc_pkg::ifc_cnt_e st;
    logic [ifc_pkg::CNT_W-1:0] timer;
    logic [ifc_pkg::CNT_W-1:0] count;
    logic [ifc_pkg::CW_W-1:0] sh_in;
    logic [ifc_pkg::CW_W-1:0] ctrl;
    logic [ifc_pkg::OUT_W-1:0] sh_out;
    logic [ifc_pkg::IRQ_W-1:0] irq_stat;
    logic [ifc_pkg::IRQ_W-1:0] irq_mask;
    logic [ifc_pkg::REF_W-1:0] ref_div;
    logic det_en;
    logic lock_prev;
    logic ack;
    logic [31:0] rdat;
    logic sdo;
    logic lock_out;
    logic irq;
    logic pump_on;
    logic [1:0] dz;
    logic force_hi;
    logic if_sensitivity_sel;
  } ifc_top_s;

  ifc_top_s r;
  ifc_top_s next_r;

  logic [ifc_pkg::SY_W-1:0] sy_level;
  logic [ifc_pkg::SY_W-1:0] sy_rise;
  logic [ifc_pkg::SY_W-1:0] sy_fall;
  logic locked;
  logic wb_req;
  logic start;
  logic [ifc_pkg::IRQ_W-1:0] ev;
  logic [ifc_pkg::IRQ_W-1:0] clr;
  logic [31:0] rd;

  // Gate length in cycles, minus one for a down counter
  function automatic logic [ifc_pkg::CNT_W-1:0] gate_cyc(input logic [1:0] sel);
    int c;
    case (sel)
      2'h0: c = P_GATE0_CYC;
      2'h1: c = P_GATE1_CYC;
      2'h2: c = P_GATE2_CYC;
      default: c = P_GATE3_CYC;
    endcase
    return ifc_pkg::CNT_W'(c - 1);
  endfunction

  // Short wait for the two short gates, long wait otherwise
  function automatic logic [ifc_pkg::CNT_W-1:0] wait_cyc(input logic [1:0] sel);
    int c;
    c = sel[1] ? P_WAIT_LONG_CYC : P_WAIT_SHORT_CYC;
    return ifc_pkg::CNT_W'(c - 1);
  endfunction

  // All pins from outside the clock domain pass two flops first
  ifc_sync #(
    .W(ifc_pkg::SY_W)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_async({I_PHASE_ERR, I_STATION_PRESENT, I_IF_INPUT_PIN,
              I_LINK_STROBE, I_LINK_CLK, I_LINK_DATA}),
    .o_level(sy_level),
    .o_rise(sy_rise),
    .o_fall(sy_fall)
  );

  // Lock verdict per reference period
  ifc_lock_det u_lock (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_enable(r.det_en),
    .i_ref_div(r.ref_div),
    .i_phase_err(sy_level[ifc_pkg::SY_PHASE]),
    .o_locked(locked)
  );

  // Register read mux
  always_comb begin
    rd = '0;
    if (I_WB_ADR == ifc_pkg::REG_CTRL) begin
      rd[ifc_pkg::CW_W-1:0] = r.ctrl;
    end else if (I_WB_ADR == ifc_pkg::REG_STATUS) begin
      rd[ifc_pkg::ST_BUSY] = (r.st == ifc_pkg::CNT_WAIT) || (r.st == ifc_pkg::CNT_GATE);
      rd[ifc_pkg::ST_DONE] = (r.st == ifc_pkg::CNT_DONE);
      rd[ifc_pkg::ST_LOCK] = r.lock_out;
      rd[ifc_pkg::ST_STATION] = sy_level[ifc_pkg::SY_STATION];
    end else if (I_WB_ADR == ifc_pkg::REG_COUNT) begin
      rd[ifc_pkg::CNT_W-1:0] = r.count;
    end else if (I_WB_ADR == ifc_pkg::REG_IRQ_STAT) begin
      rd[ifc_pkg::IRQ_W-1:0] = r.irq_stat;
    end else if (I_WB_ADR == ifc_pkg::REG_IRQ_MASK) begin
      rd[ifc_pkg::IRQ_W-1:0] = r.irq_mask;
    end else if (I_WB_ADR == ifc_pkg::REG_REF_DIV) begin
      rd[ifc_pkg::REF_W-1:0] = r.ref_div;
    end else if (I_WB_ADR == ifc_pkg::REG_LOCK_CFG) begin
      rd[0] = r.det_en;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    next_r = r;
    ev = '0;
    clr = '0;
    start = 1'b0;
    wb_req = I_WB_CYC & I_WB_STB & ~r.ack;

    // Serial link: sample on rising link clock, shift out on falling
    if (sy_rise[ifc_pkg::SY_STROBE]) begin
      next_r.sh_out = {r.lock_out, r.count};
    end else if (sy_level[ifc_pkg::SY_STROBE] && sy_fall[ifc_pkg::SY_LCLK]) begin
      next_r.sh_out = {r.sh_out[ifc_pkg::OUT_W-2:0], 1'b0};
    end
    if (sy_level[ifc_pkg::SY_STROBE] && sy_rise[ifc_pkg::SY_LCLK]) begin
      next_r.sh_in = {r.sh_in[ifc_pkg::CW_W-2:0], sy_level[ifc_pkg::SY_DATA]};
    end
    // New control takes effect only as the strobe falls
    if (sy_fall[ifc_pkg::SY_STROBE]) begin
      next_r.ctrl = r.sh_in;
      ev[ifc_pkg::IRQ_LATCH] = 1'b1;
      start = r.sh_in[ifc_pkg::CW_RUN] & ~r.ctrl[ifc_pkg::CW_RUN];
    end

    // Serial output pin: frame data, else lock level, else released high
    if (sy_level[ifc_pkg::SY_STROBE]) begin
      next_r.sdo = r.sh_out[ifc_pkg::OUT_W-1];
    end else if (r.ctrl[ifc_pkg::CW_LOCK_PIN]) begin
      next_r.sdo = r.lock_out;
    end else begin
      next_r.sdo = 1'b1;
    end

    // IF count sequencer
    case (r.st)
      ifc_pkg::CNT_IDLE: begin
        if (start) begin
          next_r.st = ifc_pkg::CNT_WAIT;
          next_r.timer = wait_cyc(r.sh_in[ifc_pkg::CW_GATE_HI:ifc_pkg::CW_GATE_LO]);
          next_r.count = '0;
        end
      end
      ifc_pkg::CNT_WAIT: begin
        // Pulses during the wait settle the input bias and are not counted
        if (r.timer == '0) begin
          next_r.st = ifc_pkg::CNT_GATE;
          next_r.timer = gate_cyc(r.ctrl[ifc_pkg::CW_GATE_HI:ifc_pkg::CW_GATE_LO]);
        end else begin
          next_r.timer = r.timer - 1'b1;
        end
      end
      ifc_pkg::CNT_GATE: begin
        if (sy_rise[ifc_pkg::SY_IF]) begin
          next_r.count = r.count + 1'b1;
        end
        if (r.timer == '0) begin
          next_r.st = ifc_pkg::CNT_DONE;
          ev[ifc_pkg::IRQ_DONE] = 1'b1;
        end else begin
          next_r.timer = r.timer - 1'b1;
        end
      end
      default: begin
        // Result stays put for readout
        next_r.count = r.count;
      end
    endcase

    // Run bit at zero holds the counter in reset
    if (!next_r.ctrl[ifc_pkg::CW_RUN]) begin
      next_r.st = ifc_pkg::CNT_IDLE;
      next_r.count = '0;
      next_r.timer = '0;
    end

    // Comparator and charge pump controls follow the latched word
    next_r.dz = r.ctrl[ifc_pkg::CW_DZ_HI:ifc_pkg::CW_DZ_LO];
    next_r.pump_on = ~r.ctrl[ifc_pkg::CW_DZ_HI];
    next_r.force_hi = r.ctrl[ifc_pkg::CW_DLC];
    next_r.if_sensitivity_sel = r.ctrl[ifc_pkg::CW_IFS];

    // Lock edges
    next_r.lock_out = locked;
    next_r.lock_prev = r.lock_out;
    ev[ifc_pkg::IRQ_UNLOCK] = r.lock_prev & ~r.lock_out;
    ev[ifc_pkg::IRQ_LOCK] = ~r.lock_prev & r.lock_out;

    // Wishbone: ack one cycle after the request, dropped the next
    next_r.ack = wb_req;
    if (wb_req) begin
      next_r.rdat = I_WB_WE ? '0 : rd;
      if (I_WB_WE) begin
        if (I_WB_ADR == ifc_pkg::REG_IRQ_MASK && I_WB_SEL[0]) begin
          next_r.irq_mask = I_WB_DAT[ifc_pkg::IRQ_W-1:0];
        end else if (I_WB_ADR == ifc_pkg::REG_REF_DIV) begin
          if (I_WB_SEL[0]) begin
            next_r.ref_div[7:0] = I_WB_DAT[7:0];
          end
          if (I_WB_SEL[1]) begin
            next_r.ref_div[15:8] = I_WB_DAT[15:8];
          end
        end else if (I_WB_ADR == ifc_pkg::REG_LOCK_CFG && I_WB_SEL[0]) begin
          next_r.det_en = I_WB_DAT[0];
        end
      end else if (I_WB_ADR == ifc_pkg::REG_IRQ_STAT) begin
        clr = r.irq_stat;
      end
    end else begin
      next_r.rdat = '0;
    end

    // Sticky status: a new event wins over a clearing read
    next_r.irq_stat = (r.irq_stat & ~clr) | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      r <= '0;
      r.st <= ifc_pkg::CNT_IDLE;
      r.ctrl <= ifc_pkg::CW_RST;
      r.irq_mask <= ifc_pkg::IRQ_MASK_RST;
      r.ref_div <= ifc_pkg::REF_DIV_RST;
      r.det_en <= 1'b1;
      r.sdo <= 1'b1;
      r.pump_on <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Every output straight from a flop
  assign O_WB_ACK = r.ack;
  assign O_WB_DAT = r.rdat;
  assign O_SDO = r.sdo;
  assign O_IF_SENSITIVITY_SEL = r.if_sensitivity_sel;
  assign O_PUMP_ACTIVE = r.pump_on;
  assign O_DEAD_ZONE_SEL = r.dz;
  assign O_DEADLOCK_CLEAR = r.force_hi;
  assign O_LOCK = r.lock_out;
  assign O_IRQ = r.irq;

endmodule
`default_nettype wire
